// ==== rtl/pfsau_consts.svh ====
// offsets, field positions, reset values and keys of the pin function
// select and address unlock block
// assumes inclusion by bare name from the package and the modules
`ifndef PFSAU_CONSTS_SVH
`define PFSAU_CONSTS_SVH

// register offsets on the internal register port
`define PFSAU_ADDR_W 8
`define PFSAU_OFF_TARGET_ADDR 8'h09
`define PFSAU_OFF_PIN_FUNC 8'h0b
`define PFSAU_OFF_UNLOCK 8'h0d

// field positions
`define PFSAU_SEL_W 5
`define PFSAU_PIN0_SEL_LSB 0
`define PFSAU_PIN1_SEL_LSB 8
`define PFSAU_GUARD_LSB 8
`define PFSAU_TADDR_LSB 1
`define PFSAU_TADDR_W 7

// reset values
`define PFSAU_SEL_RST 5'h00
`define PFSAU_UNLOCK_RST 16'h0000
`define PFSAU_TADDR_RST 7'h32

// write guard and unlock keys
`define PFSAU_GUARD_KEY 8'had
`define PFSAU_KEY_ALWAYS 16'h04ad
`define PFSAU_KEY_PIN0 16'h44ad
`define PFSAU_KEY_PIN1 16'h84ad
`define PFSAU_KEY_BOTH 16'hc4ad

// function selector codes
`define PFSAU_FN_LEGACY 5'h00
`define PFSAU_FN_INT 5'h01
`define PFSAU_FN_FRAME 5'h02
`define PFSAU_FN_LED_A 5'h05
`define PFSAU_FN_LED_B 5'h06
`define PFSAU_FN_LED_AB 5'h07
`define PFSAU_FN_DC_A 5'h0c
`define PFSAU_FN_DC_B 5'h0d
`define PFSAU_FN_DC_ANY 5'h0e
`define PFSAU_FN_TOGGLE 5'h0f
`define PFSAU_FN_LOW 5'h10
`define PFSAU_FN_HIGH 5'h11
`define PFSAU_FN_OSC 5'h13

`endif

// ==== rtl/pfsau_pin_mux.sv ====
// one general pin: selects its source from the function code
// assumes all event inputs already on clk_i and a synchronised reset
`timescale 1ns/100ps
module pfsau_pin_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pfsau_pkg::pfsau_sel_t sel_i,
  input wire logic legacy_i,
  input wire logic legacy_oe_n_i,
  input wire logic int_i,
  input wire logic int_oe_n_i,
  input wire logic frame_i,
  input wire logic led_a_i,
  input wire logic led_b_i,
  input wire logic dc_a_i,
  input wire logic dc_b_i,
  input wire logic sample_i,
  input wire logic osc_i,
  output logic pin_o,
  output logic pin_oe_n_o
);
  import pfsau_pkg::*;

  logic toggle_r;
  logic pin_nxt;
  logic oe_n_nxt;

  // half-rate square wave, flips once per sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_r <= 1'b0;
    end else if (sample_i) begin
      toggle_r <= ~toggle_r;
    end
  end

  // source selection from the function code
  always_comb begin
    pin_nxt = 1'b0;
    oe_n_nxt = 1'b0;
    case (sel_i)
      PFSAU_LEGACY: begin
        pin_nxt = legacy_i;
        oe_n_nxt = legacy_oe_n_i;
      end
      PFSAU_INT: begin
        pin_nxt = int_i;
        oe_n_nxt = int_oe_n_i;
      end
      PFSAU_FRAME: pin_nxt = frame_i;
      PFSAU_LED_A: pin_nxt = led_a_i;
      PFSAU_LED_B: pin_nxt = led_b_i;
      PFSAU_LED_AB: pin_nxt = led_a_i | led_b_i;
      PFSAU_DC_A: pin_nxt = dc_a_i;
      PFSAU_DC_B: pin_nxt = dc_b_i;
      PFSAU_DC_ANY: pin_nxt = dc_a_i | dc_b_i;
      PFSAU_TOGGLE: pin_nxt = toggle_r;
      PFSAU_LOW: pin_nxt = 1'b0;
      PFSAU_HIGH: pin_nxt = 1'b1;
      PFSAU_OSC: pin_nxt = osc_i;
      default: pin_nxt = 1'b0;
    endcase
  end

  // registered pin drive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b0;
    end else begin
      pin_o <= pin_nxt;
      pin_oe_n_o <= oe_n_nxt;
    end
  end
endmodule : pfsau_pin_mux

// ==== rtl/pfsau_pkg.sv ====
// types of the pin function select and address unlock block
// assumes pfsau_consts.svh on the include path
package pfsau_pkg;
  `include "pfsau_consts.svh"

  typedef logic [`PFSAU_SEL_W-1:0] pfsau_sel_t;

  // pin function selector codes
  typedef enum logic [`PFSAU_SEL_W-1:0] {
    PFSAU_LEGACY = `PFSAU_FN_LEGACY,
    PFSAU_INT = `PFSAU_FN_INT,
    PFSAU_FRAME = `PFSAU_FN_FRAME,
    PFSAU_LED_A = `PFSAU_FN_LED_A,
    PFSAU_LED_B = `PFSAU_FN_LED_B,
    PFSAU_LED_AB = `PFSAU_FN_LED_AB,
    PFSAU_DC_A = `PFSAU_FN_DC_A,
    PFSAU_DC_B = `PFSAU_FN_DC_B,
    PFSAU_DC_ANY = `PFSAU_FN_DC_ANY,
    PFSAU_TOGGLE = `PFSAU_FN_TOGGLE,
    PFSAU_LOW = `PFSAU_FN_LOW,
    PFSAU_HIGH = `PFSAU_FN_HIGH,
    PFSAU_OSC = `PFSAU_FN_OSC
  } pfsau_func_e;
endpackage : pfsau_pkg

// ==== rtl/pfsau_top.sv ====
// pin function select and address unlock: registers, unlock check,
// frame window and the two general pin selectors
// assumes a register port from the serial interface decoder on clk_i,
// sequencer events on clk_i, oscillator and pin levels from outside
`timescale 1ns/100ps
`include "pfsau_consts.svh"

// Behaviour
// - pin 0 code zero gives the legacy interrupt pin behaviour.
// - code one puts the configured interrupt on the pin.
// - code two frames first slot start to last slot end.
// - codes 5, 6, 7 give slot A, slot B, both led pulses.
// - codes C, D, E mark data cycles for A, B, any slot.
// - code F toggles every sample, half sample rate square wave.
// - code 13 passes the 32 kHz oscillator to the pin.
// - pin 1 offers slot A, B and both led pulses too.
// - pin 1 offers data cycle marks and the half-rate toggle.
// - key 04AD in the unlock register always allows address change.
// - key 44AD allows address change only while pin 0 is high.
// - key 84AD allows address change only while pin 1 is high.
// - key C4AD allows address change only with both pins high.
// - pin 1 selector at bits 12..8; zero gives legacy strobe pin.
module pfsau_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`PFSAU_ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [15:0] reg_rdata_o,
  output logic [`PFSAU_TADDR_W-1:0] target_addr_o,
  input wire logic legacy_int_i,
  input wire logic legacy_int_oe_n_i,
  input wire logic legacy_strobe_i,
  input wire logic int_i,
  input wire logic int_oe_n_i,
  input wire logic seq_first_start_i,
  input wire logic seq_last_end_i,
  input wire logic led_a_i,
  input wire logic led_b_i,
  input wire logic data_cycle_a_i,
  input wire logic data_cycle_b_i,
  input wire logic sample_i,
  input wire logic osc32k_i,
  input wire logic pin0_i,
  output logic pin0_o,
  output logic pin0_oe_n_o,
  input wire logic pin1_i,
  output logic pin1_o,
  output logic pin1_oe_n_o
);
  import pfsau_pkg::*;

  localparam int PIN_N = 2;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [1:0] pin0_sync_r;
  logic [1:0] pin1_sync_r;
  logic [1:0] osc_sync_r;
  logic frame_r;
  logic frame_nxt;
  pfsau_sel_t pin0_sel_r;
  pfsau_sel_t pin1_sel_r;
  logic [15:0] unlock_r;
  logic [`PFSAU_TADDR_W-1:0] taddr_r;
  logic change_ok;
  logic addr_wr;
  logic [15:0] rdata_nxt;
  pfsau_sel_t sel_arr [PIN_N];
  logic legacy_arr [PIN_N];
  logic legacy_oe_n_arr [PIN_N];
  logic pin_arr [PIN_N];
  logic oe_n_arr [PIN_N];

  // reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pin levels and oscillator into the clock domain
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin0_sync_r <= 2'h0;
      pin1_sync_r <= 2'h0;
      osc_sync_r <= 2'h0;
    end else begin
      pin0_sync_r <= {pin0_sync_r[0], pin0_i};
      pin1_sync_r <= {pin1_sync_r[0], pin1_i};
      osc_sync_r <= {osc_sync_r[0], osc32k_i};
    end
  end

  // frame window: set by first slot start, cleared by last slot end
  always_comb begin
    frame_nxt = frame_r;
    if (seq_last_end_i) begin
      frame_nxt = 1'b0;
    end
    if (seq_first_start_i) begin
      frame_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= 1'b0;
    end else begin
      frame_r <= frame_nxt;
    end
  end

  // pin function selectors; reserved bits are not stored
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin0_sel_r <= `PFSAU_SEL_RST;
      pin1_sel_r <= `PFSAU_SEL_RST;
    end else if (reg_wr_i && reg_addr_i == `PFSAU_OFF_PIN_FUNC) begin
      pin0_sel_r <= reg_wdata_i[`PFSAU_PIN0_SEL_LSB +: `PFSAU_SEL_W];
      pin1_sel_r <= reg_wdata_i[`PFSAU_PIN1_SEL_LSB +: `PFSAU_SEL_W];
    end
  end

  // unlock key register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      unlock_r <= `PFSAU_UNLOCK_RST;
    end else if (reg_wr_i && reg_addr_i == `PFSAU_OFF_UNLOCK) begin
      unlock_r <= reg_wdata_i;
    end
  end

  // key decode against the live pin levels
  always_comb begin
    case (unlock_r)
      `PFSAU_KEY_ALWAYS: change_ok = 1'b1;
      `PFSAU_KEY_PIN0: change_ok = pin0_sync_r[1];
      `PFSAU_KEY_PIN1: change_ok = pin1_sync_r[1];
      `PFSAU_KEY_BOTH: change_ok = pin0_sync_r[1] & pin1_sync_r[1];
      default: change_ok = 1'b0;
    endcase
  end

  // guard byte must accompany the address write
  assign addr_wr = reg_wr_i && reg_addr_i == `PFSAU_OFF_TARGET_ADDR &&
                   reg_wdata_i[`PFSAU_GUARD_LSB +: 8] == `PFSAU_GUARD_KEY;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      taddr_r <= `PFSAU_TADDR_RST;
    end else if (addr_wr && change_ok) begin
      taddr_r <= reg_wdata_i[`PFSAU_TADDR_LSB +: `PFSAU_TADDR_W];
    end
  end
  assign target_addr_o = taddr_r;

  // read mux; guard byte and reserved bits read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr_i)
      `PFSAU_OFF_TARGET_ADDR: begin
        rdata_nxt[`PFSAU_TADDR_LSB +: `PFSAU_TADDR_W] = taddr_r;
      end
      `PFSAU_OFF_PIN_FUNC: begin
        rdata_nxt[`PFSAU_PIN0_SEL_LSB +: `PFSAU_SEL_W] = pin0_sel_r;
        rdata_nxt[`PFSAU_PIN1_SEL_LSB +: `PFSAU_SEL_W] = pin1_sel_r;
      end
      `PFSAU_OFF_UNLOCK: rdata_nxt = unlock_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // registered read data
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // per-pin sources: pin 0 legacy is the interrupt, pin 1 the strobe
  assign sel_arr[0] = pin0_sel_r;
  assign sel_arr[1] = pin1_sel_r;
  assign legacy_arr[0] = legacy_int_i;
  assign legacy_oe_n_arr[0] = legacy_int_oe_n_i;
  assign legacy_arr[1] = legacy_strobe_i;
  assign legacy_oe_n_arr[1] = 1'b0;

  // one selector per general pin
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    pfsau_pin_mux u_mux (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .sel_i(sel_arr[g]),
      .legacy_i(legacy_arr[g]),
      .legacy_oe_n_i(legacy_oe_n_arr[g]),
      .int_i(int_i),
      .int_oe_n_i(int_oe_n_i),
      .frame_i(frame_r),
      .led_a_i(led_a_i),
      .led_b_i(led_b_i),
      .dc_a_i(data_cycle_a_i),
      .dc_b_i(data_cycle_b_i),
      .sample_i(sample_i),
      .osc_i(osc_sync_r[1]),
      .pin_o(pin_arr[g]),
      .pin_oe_n_o(oe_n_arr[g])
    );
  end

  assign pin0_o = pin_arr[0];
  assign pin0_oe_n_o = oe_n_arr[0];
  assign pin1_o = pin_arr[1];
  assign pin1_oe_n_o = oe_n_arr[1];
endmodule : pfsau_top

// ==== verif/pfsau_host_model.sv ====
// host side: register writes and the resolved pin wires
// assumes pull-ups on both pins and the block's clock
`timescale 1ns/100ps
`include "pfsau_consts.svh"
module pfsau_host_model (
  input wire logic clk_i,
  input wire logic pin0_o,
  input wire logic pin0_oe_n_o,
  input wire logic pin1_o,
  input wire logic pin1_oe_n_o,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic [15:0] reg_wdata_o = 16'h0000,
  output logic reg_wr_o = 1'b0,
  output logic pin0_lvl_o,
  output logic pin1_lvl_o
);
  // a released pin floats up to the pull-up
  assign pin0_lvl_o = pin0_oe_n_o ? 1'b1 : pin0_o;
  assign pin1_lvl_o = pin1_oe_n_o ? 1'b1 : pin1_o;
  // one strobe edge, then stale data inverted and a quiet edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i) #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
    @(posedge clk_i) #1;
  endtask : wr
  task automatic set_sel(input logic [4:0] c0, c1);
    wr(`PFSAU_OFF_PIN_FUNC, {3'h0, c1, 3'h0, c0});
  endtask : set_sel
  task automatic set_addr(input logic [6:0] a);
    wr(`PFSAU_OFF_TARGET_ADDR, {`PFSAU_GUARD_KEY, a, 1'b0});
  endtask : set_addr
  // point the read port at a register and let it settle
  task automatic look(input logic [7:0] a);
    reg_addr_o = a;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : look
endmodule : pfsau_host_model

// ==== verif/pfsau_top_assertions.sv ====
// port checker of the pin select and unlock block
// assumes one clock clk_i and async low reset_n_i
`timescale 1ns/100ps
`include "pfsau_consts.svh"
module pfsau_top_assertions (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] target_addr_o,
  input wire logic legacy_int_i,
  input wire logic legacy_int_oe_n_i,
  input wire logic int_i,
  input wire logic seq_first_start_i,
  input wire logic led_a_i,
  input wire logic led_b_i,
  input wire logic data_cycle_b_i,
  input wire logic sample_i,
  input wire logic pin0_o,
  input wire logic pin0_oe_n_o,
  input wire logic pin1_o
);
  logic [4:0] s0_r, s1_r;
  logic [15:0] key_r;
  logic [2:0] rdy_r;
  logic ok, lk;
  // checks start once the internal reset copy has let go
  assign ok = rdy_r[2];
  assign lk = !(key_r inside {`PFSAU_KEY_ALWAYS, `PFSAU_KEY_PIN0,
    `PFSAU_KEY_PIN1, `PFSAU_KEY_BOTH});
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of selectors and key
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s0_r <= 5'h00;
      s1_r <= 5'h00;
      key_r <= 16'h0000;
      rdy_r <= 3'h0;
    end else begin
      rdy_r <= {rdy_r[1:0], 1'b1};
      if (reg_wr_i && reg_addr_i == `PFSAU_OFF_PIN_FUNC) begin
        s0_r <= reg_wdata_i[4:0];
        s1_r <= reg_wdata_i[12:8];
      end
      if (reg_wr_i && reg_addr_i == `PFSAU_OFF_UNLOCK) key_r <= reg_wdata_i;
    end
  end
  a_legacy_pin0: assert property (
    ok && s0_r == `PFSAU_FN_LEGACY |=> pin0_o == $past(legacy_int_i)
    && pin0_oe_n_o == $past(legacy_int_oe_n_i)) else $error("legacy pin0");
  a_int_route: assert property (
    ok && s0_r == `PFSAU_FN_INT |=> pin0_o == $past(int_i))
    else $error("int route");
  a_frame_open: assert property (
    ok && s0_r == `PFSAU_FN_FRAME && seq_first_start_i |=> ##1 pin0_o)
    else $error("frame open");
  a_led_both: assert property (
    ok && s0_r == `PFSAU_FN_LED_AB |=>
    pin0_o == ($past(led_a_i) || $past(led_b_i)))
    else $error("led both");
  a_toggle_flip: assert property (
    ok && s0_r == `PFSAU_FN_TOGGLE && sample_i |=> ##1
    pin0_o != $past(pin0_o)) else $error("toggle");
  a_const_high: assert property (
    ok && s1_r == `PFSAU_FN_HIGH |=> pin1_o) else $error("const high");
  a_dc_pin1: assert property (
    ok && s1_r == `PFSAU_FN_DC_B |=> pin1_o == $past(data_cycle_b_i))
    else $error("dc pin1");
  a_addr_locked: assert property (
    ok && lk && reg_wr_i && reg_addr_i == `PFSAU_OFF_TARGET_ADDR |=>
    $stable(target_addr_o)) else $error("addr locked");
endmodule : pfsau_top_assertions

bind pfsau_top pfsau_top_assertions i_pfsau_top_assertions (.clk_i,
  .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .target_addr_o,
  .legacy_int_i, .legacy_int_oe_n_i, .int_i, .seq_first_start_i, .led_a_i,
  .led_b_i, .data_cycle_b_i, .sample_i, .pin0_o, .pin0_oe_n_o, .pin1_o);

// ==== verif/pin_function_select_and_addr_unlock_tb.sv ====
// bench: pin code table, then frame, toggle, oscillator, keys, reset
// assumes rtl and host model compiled first
`timescale 1ns/100ps
`include "pfsau_consts.svh"
module pin_function_select_and_addr_unlock_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [6:0] s = 7'h00;
  logic oen = 1'b0, fs = 1'b0, le = 1'b0, smp = 1'b0, osc = 1'b0, lv;
  logic [7:0] ra;
  logic [15:0] wd, rd;
  logic wr, p0, p0n, p1, p1n, l0, l1;
  logic [6:0] ta;
  int failures = 0, samples_checked = 0, cyc = 0;
  logic [13:0] rows [17] = '{{5'h00,7'h01,2'h2}, {5'h00,7'h40,2'h1},
    {5'h01,7'h02,2'h3}, {5'h01,7'h7d,2'h0}, {5'h05,7'h04,2'h3},
    {5'h05,7'h7b,2'h0}, {5'h06,7'h08,2'h3}, {5'h07,7'h04,2'h3},
    {5'h07,7'h08,2'h3}, {5'h07,7'h73,2'h0}, {5'h0c,7'h10,2'h3},
    {5'h0d,7'h20,2'h3}, {5'h0d,7'h5f,2'h0}, {5'h0e,7'h20,2'h3},
    {5'h0e,7'h4f,2'h0}, {5'h10,7'h7f,2'h0}, {5'h11,7'h00,2'h3}};
  // key, pin0 high, pin1 high, address written, address expected
  logic [31:0] ul [10] = '{{16'h1234,2'h0,7'h11,7'h32},
    {16'h04ad,2'h0,7'h11,7'h11}, {16'h44ad,2'h1,7'h22,7'h11},
    {16'h44ad,2'h2,7'h22,7'h22}, {16'h84ad,2'h2,7'h33,7'h22},
    {16'h84ad,2'h1,7'h33,7'h33}, {16'hc4ad,2'h2,7'h44,7'h33},
    {16'hc4ad,2'h1,7'h44,7'h33}, {16'hc4ad,2'h3,7'h44,7'h44},
    {16'h04ae,2'h3,7'h55,7'h44}};
  pfsau_top i_pfsau_top (.clk_i, .reset_n_i, .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rdata_o(rd), .target_addr_o(ta),
    .legacy_int_i(s[0]), .legacy_int_oe_n_i(oen), .legacy_strobe_i(s[6]),
    .int_i(s[1]), .int_oe_n_i(oen), .seq_first_start_i(fs),
    .seq_last_end_i(le), .led_a_i(s[2]), .led_b_i(s[3]),
    .data_cycle_a_i(s[4]), .data_cycle_b_i(s[5]), .sample_i(smp),
    .osc32k_i(osc), .pin0_i(l0), .pin0_o(p0), .pin0_oe_n_o(p0n),
    .pin1_i(l1), .pin1_o(p1), .pin1_oe_n_o(p1n));
  pfsau_host_model i_pfsau_host_model (.clk_i, .pin0_o(p0),
    .pin0_oe_n_o(p0n), .pin1_o(p1), .pin1_oe_n_o(p1n), .reg_addr_o(ra),
    .reg_wdata_o(wd), .reg_wr_o(wr), .pin0_lvl_o(l0), .pin1_lvl_o(l1));
  // clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task end_of_test;
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    tick(2);
    reset_n_i = 1'b1;
    tick(3);
    chk(ta, 7'h32);
    i_pfsau_host_model.look(`PFSAU_OFF_TARGET_ADDR);
    chk(rd, 16'h0064);
    foreach (rows[i]) begin
      i_pfsau_host_model.set_sel(rows[i][13:9], rows[i][13:9]);
      s = rows[i][8:2];
      tick(2);
      chk(p0, rows[i][1]);
      chk(p1, rows[i][0]);
    end
    i_pfsau_host_model.set_sel(5'h00, 5'h01);
    oen = 1'b1;
    tick(2);
    chk({p0n, p1n}, 2'h3);
    oen = 1'b0;
    i_pfsau_host_model.set_sel(5'h02, 5'h02);
    fs = 1'b1;
    tick(1);
    fs = 1'b0;
    tick(5);
    chk({p0, p1}, 2'h3);
    le = 1'b1;
    tick(1);
    le = 1'b0;
    tick(1);
    chk({p0, p1}, 2'h0);
    i_pfsau_host_model.set_sel(5'h0f, 5'h0f);
    repeat (2) begin
      lv = p0;
      smp = 1'b1;
      tick(1);
      smp = 1'b0;
      tick(2);
      chk(p0, !lv);
    end
    i_pfsau_host_model.set_sel(5'h13, 5'h13);
    osc = 1'b1;
    tick(4);
    chk({p0, p1}, 2'h3);
    osc = 1'b0;
    tick(4);
    chk({p0, p1}, 2'h0);
    i_pfsau_host_model.look(`PFSAU_OFF_PIN_FUNC);
    chk(rd, 16'h1313);
    foreach (ul[i]) begin
      i_pfsau_host_model.wr(`PFSAU_OFF_UNLOCK, ul[i][31:16]);
      i_pfsau_host_model.set_sel({4'h8, ul[i][15]}, {4'h8, ul[i][14]});
      tick(4);
      i_pfsau_host_model.set_addr(ul[i][13:7]);
      chk(ta, ul[i][6:0]);
    end
    i_pfsau_host_model.look(`PFSAU_OFF_UNLOCK);
    chk(rd, 16'h04ae);
    reset_n_i = 1'b0;
    tick(1);
    chk({ta, p0}, 8'h64);
    reset_n_i = 1'b1;
    tick(3);
    chk(ta, 7'h32);
    i_pfsau_host_model.look(`PFSAU_OFF_PIN_FUNC);
    chk(rd, 16'h0000);
    i_pfsau_host_model.look(`PFSAU_OFF_UNLOCK);
    chk(rd, 16'h0000);
    end_of_test();
  end
endmodule : pin_function_select_and_addr_unlock_tb
